// *** rtl/atsr_regs.sv ***
// Trim and status register bank with AXI4-Lite slave
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module atsr_regs
   import atsr_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire atsr_axil_req_s   axil_req,
   output atsr_axil_rsp_s        axil_rsp,
   input  wire logic [POS_W-1:0] edge_capture_position,
   input  wire logic             edge_capture_toggle,
   output atsr_ctrl_s            ctrl
);

   atsr_state_s          st_r;
   atsr_state_s          st_nxt;
   logic [POS_W:0]       cap_sync;
   logic                 cap_evt;
   logic                 wr_fire;
   logic                 rd_fire;
   logic [7:0]           wr_idx;
   logic                 wr_hit;
   logic [7:0]           rd_idx;
   logic                 rd_hit;
   logic [AXI_DW-1:0]    rd_word;

   // Capture word and its toggle arrive from the edge detector's domain
   atsr_sync #(.W(POS_W + 1)) u_cap_sync (
      .clk (clk),
      .rst (rst),
      .d   ({edge_capture_toggle, edge_capture_position}),
      .q   (cap_sync)
   );

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      logic [15:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      return s[0] ? d[7:0] : old;
   endfunction

   function automatic logic known_idx(input logic [7:0] i);
      return (i == IDX_CAPTURE_POS) || (i == IDX_TRIM_A) || (i == IDX_TRIM_B) ||
             (i == IDX_REF_BYPASS) || (i == IDX_STAMP_CTRL) || (i == IDX_PREEMPH) ||
             (i == IDX_PLL_LOOP3) || (i == IDX_CAPTURE_SEL);
   endfunction

   assign wr_idx  = st_r.aw_addr[9:2];
   assign wr_hit  = (st_r.aw_addr[1:0] == 2'h0) && known_idx(wr_idx);
   assign rd_idx  = axil_req.araddr[9:2];
   assign rd_hit  = (axil_req.araddr[1:0] == 2'h0) && known_idx(rd_idx);
   assign wr_fire = st_r.aw_ok && st_r.w_ok && !st_r.bvalid;
   assign rd_fire = axil_req.arvalid && !st_r.rvalid;
   assign cap_evt = cap_sync[POS_W] != st_r.cap_tgl;

   // Read mux; narrow registers sit in the low bits with zero above
   always_comb begin
      rd_word = '0;
      case (rd_idx)
         IDX_CAPTURE_POS: rd_word[POS_W-1:0] = st_r.cap_pos;
         IDX_TRIM_A:      rd_word[TRIM_W-1:0] = st_r.trim_a;
         IDX_TRIM_B:      rd_word[TRIM_W-1:0] = st_r.trim_b;
         IDX_REF_BYPASS:  rd_word[7:0] = st_r.ref_byp;
         IDX_STAMP_CTRL:  rd_word[7:0] = st_r.stamp;
         IDX_PREEMPH:     rd_word[7:0] = st_r.pe;
         IDX_PLL_LOOP3:   rd_word[7:0] = st_r.pll3;
         IDX_CAPTURE_SEL: rd_word[7:0] = st_r.sel;
         default:         rd_word = '0;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      // Write address and data are taken in either order
      if (axil_req.awvalid && !st_r.aw_ok && !st_r.bvalid) begin
         st_nxt.aw_ok   = 1'b1;
         st_nxt.aw_addr = axil_req.awaddr;
      end
      if (axil_req.wvalid && !st_r.w_ok && !st_r.bvalid) begin
         st_nxt.w_ok   = 1'b1;
         st_nxt.w_data = axil_req.wdata;
         st_nxt.w_strb = axil_req.wstrb;
      end
      if (st_r.bvalid && axil_req.bready) begin
         st_nxt.bvalid = 1'b0;
      end
      // Position tracks the newest captured edge; software writes never reach it
      if (cap_evt) begin
         st_nxt.cap_tgl = cap_sync[POS_W];
         st_nxt.cap_pos = cap_sync[POS_W-1:0];
      end
      if (wr_fire) begin
         st_nxt.aw_ok  = 1'b0;
         st_nxt.w_ok   = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
         if (wr_hit) begin
            case (wr_idx)
               // Any trim code is stored; low codes are only a software concern
               IDX_TRIM_A: begin
                  st_nxt.trim_a = merge16(st_r.trim_a, st_r.w_data, st_r.w_strb);
               end
               IDX_TRIM_B: begin
                  st_nxt.trim_b = merge16(st_r.trim_b, st_r.w_data, st_r.w_strb);
               end
               // Reserved bits are kept as written
               IDX_REF_BYPASS: begin
                  st_nxt.ref_byp = merge8(st_r.ref_byp, st_r.w_data, st_r.w_strb);
               end
               IDX_STAMP_CTRL: begin
                  st_nxt.stamp = merge8(st_r.stamp, st_r.w_data, st_r.w_strb);
               end
               IDX_PREEMPH: begin
                  st_nxt.pe = merge8(st_r.pe, st_r.w_data, st_r.w_strb);
               end
               IDX_PLL_LOOP3: begin
                  st_nxt.pll3 = merge8(st_r.pll3, st_r.w_data, st_r.w_strb);
               end
               IDX_CAPTURE_SEL: begin
                  st_nxt.sel = merge8(st_r.sel, st_r.w_data, st_r.w_strb);
               end
               // Capture position is status only; its writes end here with no effect
               default: begin
                  st_nxt.sel = st_r.sel;
               end
            endcase
         end
      end
      if (st_r.rvalid && axil_req.rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (rd_fire) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = rd_hit ? rd_word : '0;
         st_nxt.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r        <= '0;
         st_r.cap_pos <= RST_POS;
         st_r.trim_a <= RST_TRIM;
         st_r.trim_b <= RST_TRIM;
         st_r.ref_byp <= RST_CTRL8;
         st_r.stamp  <= RST_CTRL8;
         st_r.pe     <= RST_CTRL8;
         st_r.pll3   <= RST_PLL3;
         st_r.sel    <= RST_CTRL8;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign axil_rsp.awready = !st_r.aw_ok && !st_r.bvalid;
   assign axil_rsp.wready  = !st_r.w_ok && !st_r.bvalid;
   assign axil_rsp.bvalid  = st_r.bvalid;
   assign axil_rsp.bresp   = st_r.bresp;
   assign axil_rsp.arready = !st_r.rvalid;
   assign axil_rsp.rvalid  = st_r.rvalid;
   assign axil_rsp.rdata   = st_r.rdata;
   assign axil_rsp.rresp   = st_r.rresp;

   // Trim codes drive the range DACs as-is; the analog side keeps the mapping monotonic
   assign ctrl.trim_a                 = st_r.trim_a;
   assign ctrl.trim_b                 = st_r.trim_b;
   assign ctrl.reference_bypass       = st_r.ref_byp[BIT_REF_BYPASS];
   assign ctrl.stamp_receiver_enable  = st_r.stamp[BIT_STAMP_EN];
   assign ctrl.stamp_pecl_mode        = st_r.stamp[BIT_STAMP_PECL];
   assign ctrl.pll_loop_control_three = st_r.pll3;
   // Forced to zero while calibration owns the edge timing
   assign ctrl.capture_delay_select   = st_r.sel[BIT_AUTO_CAL] ? '0 :
                                        st_r.sel[SEL_LSB +: SEL_W];

   // One global setting fans out; per-lane control is not offered
   for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
      assign ctrl.lane_preemphasis[g]       = st_r.pe[PE_LSB +: PE_W];
      assign ctrl.lane_preemphasis_boost[g] = st_r.pe[BIT_PE_BOOST];
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic wr_full;
   assign wr_full = wr_fire && wr_hit && (st_r.w_strb == 4'hF);

   AST_POS_WRITE_IGNORED: assert property (
      (wr_fire && wr_idx == IDX_CAPTURE_POS && !cap_evt) |=> $stable(st_r.cap_pos))
      else $error("capture position changed by a write");

   AST_POS_CAPTURE: assert property (
      cap_evt |=> (st_r.cap_pos == $past(cap_sync[POS_W-1:0])))
      else $error("capture position not loaded on edge event");

   AST_POS_READ: assert property (
      (rd_fire && rd_hit && rd_idx == IDX_CAPTURE_POS) |=>
         axil_rsp.rvalid && axil_rsp.rdata == {8'h00, $past(st_r.cap_pos)})
      else $error("capture position read mismatch");

   AST_TRIM_A_WRITE: assert property (
      (wr_full && wr_idx == IDX_TRIM_A) |=> ctrl.trim_a == $past(st_r.w_data[15:0]))
      else $error("trim A not stored");

   AST_TRIM_B_WRITE: assert property (
      (wr_full && wr_idx == IDX_TRIM_B) |=> ctrl.trim_b == $past(st_r.w_data[15:0]))
      else $error("trim B not stored");

   AST_RESET_VALUES: assert property (
      $fell(rst) |-> (ctrl.trim_a == RST_TRIM && ctrl.trim_b == RST_TRIM &&
                      st_r.pe == RST_CTRL8 && st_r.pll3 == RST_PLL3 &&
                      !ctrl.reference_bypass && !ctrl.stamp_receiver_enable))
      else $error("wrong value after reset");

   AST_REF_BYPASS: assert property (
      (wr_full && wr_idx == IDX_REF_BYPASS) |=>
         ctrl.reference_bypass == $past(st_r.w_data[BIT_REF_BYPASS]))
      else $error("reference bypass not applied");

   AST_STAMP_CTRL: assert property (
      (wr_full && wr_idx == IDX_STAMP_CTRL) |=>
         ctrl.stamp_receiver_enable == $past(st_r.w_data[BIT_STAMP_EN]) &&
         ctrl.stamp_pecl_mode == $past(st_r.w_data[BIT_STAMP_PECL]))
      else $error("timestamp control not applied");

   AST_LANE_PREEMPH: assert property (
      (wr_full && wr_idx == IDX_PREEMPH) |=>
         ctrl.lane_preemphasis[NUM_LANES-1] == $past(st_r.w_data[2:0]) &&
         ctrl.lane_preemphasis[0] == ctrl.lane_preemphasis[NUM_LANES-1])
      else $error("lane pre-emphasis not applied to all lanes");

   AST_LANE_BOOST: assert property (
      (wr_full && wr_idx == IDX_PREEMPH) |=>
         ctrl.lane_preemphasis_boost == {NUM_LANES{$past(st_r.w_data[BIT_PE_BOOST])}})
      else $error("boost not applied to all lanes");

   AST_PLL_WRITE: assert property (
      (wr_full && wr_idx == IDX_PLL_LOOP3) |=>
         ctrl.pll_loop_control_three == $past(st_r.w_data[7:0]))
      else $error("PLL loop control not stored");

   AST_SEL_AUTO_ZERO: assert property (
      st_r.sel[BIT_AUTO_CAL] |-> ctrl.capture_delay_select == '0)
      else $error("delay select nonzero during auto calibration");

   AST_WRITE_RESP: assert property (
      wr_fire |=> axil_rsp.bvalid && axil_rsp.bresp == $past(wr_hit ? RESP_OKAY : RESP_SLVERR))
      else $error("write response missing or wrong");

   AST_RDATA_HOLD: assert property (
      (axil_rsp.rvalid && !axil_req.rready) |=> axil_rsp.rvalid && $stable(axil_rsp.rdata))
      else $error("read data dropped before taken");

   AST_SEL_WRITE: assert property (
      (wr_full && wr_idx == IDX_CAPTURE_SEL && !st_r.w_data[BIT_AUTO_CAL]) |=>
         ctrl.capture_delay_select == $past(st_r.w_data[SEL_LSB +: SEL_W]))
      else $error("capture delay select not applied");

   // A control may only move on a committed write to its own index
   AST_TRIM_A_HOLD: assert property (
      !(wr_fire && wr_hit && wr_idx == IDX_TRIM_A) |=> $stable(ctrl.trim_a))
      else $error("trim A changed without a write");

   AST_PLL_HOLD: assert property (
      !(wr_fire && wr_hit && wr_idx == IDX_PLL_LOOP3) |=>
         $stable(ctrl.pll_loop_control_three))
      else $error("PLL loop control changed without a write");

   AST_STAMP_HOLD: assert property (
      !(wr_fire && wr_hit && wr_idx == IDX_STAMP_CTRL) |=>
         $stable(ctrl.stamp_receiver_enable) && $stable(ctrl.stamp_pecl_mode))
      else $error("timestamp control changed without a write");

   AST_UNMAPPED_DROP: assert property (
      (wr_fire && !wr_hit) |=> $stable(st_r.trim_a) && $stable(st_r.trim_b) &&
         $stable(st_r.pe) && $stable(st_r.sel) && $stable(st_r.pll3))
      else $error("write to unmapped place changed a register");

   AST_RESET_REST: assert property (
      $fell(rst) |-> (ctrl.lane_preemphasis_boost == '0 && ctrl.lane_preemphasis[0] == '0 &&
                      ctrl.capture_delay_select == '0 && !ctrl.stamp_pecl_mode))
      else $error("wrong control value after reset");

   AST_READ_RESP: assert property (
      rd_fire |=> axil_rsp.rvalid && axil_rsp.rresp == $past(rd_hit ? RESP_OKAY : RESP_SLVERR))
      else $error("read response missing or wrong");

   AST_BRESP_HOLD: assert property (
      (axil_rsp.bvalid && !axil_req.bready) |=> axil_rsp.bvalid && $stable(axil_rsp.bresp))
      else $error("write response dropped before taken");

   COV_LOW_TRIM: cover property (wr_full && wr_idx == IDX_TRIM_A && st_r.w_data[15:0] < TRIM_MIN);
   COV_CAPTURE_READ: cover property (cap_evt ##[1:20] (rd_fire && rd_idx == IDX_CAPTURE_POS));
   COV_UNMAPPED: cover property (rd_fire && !rd_hit);
   COV_AUTO_CAL: cover property (wr_full && wr_idx == IDX_CAPTURE_SEL && st_r.w_data[BIT_AUTO_CAL]);

endmodule
`default_nettype wire

// *** common/atsr_pkg.sv ***
// Constants, types and register map of the converter trim and status register bank
package atsr_pkg;

   localparam int AXI_AW = 10;
   localparam int AXI_DW = 32;
   localparam int POS_W  = 24;
   localparam int TRIM_W = 16;
   localparam int SEL_W  = 4;
   localparam int PE_W   = 3;
   localparam int NUM_LANES = 16;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] IDX_CAPTURE_POS = 8'h2C;
   localparam logic [7:0] IDX_TRIM_A      = 8'h30;
   localparam logic [7:0] IDX_TRIM_B      = 8'h32;
   localparam logic [7:0] IDX_REF_BYPASS  = 8'h38;
   localparam logic [7:0] IDX_STAMP_CTRL  = 8'h3B;
   localparam logic [7:0] IDX_PREEMPH     = 8'h48;
   localparam logic [7:0] IDX_PLL_LOOP3   = 8'h4F;
   localparam logic [7:0] IDX_CAPTURE_SEL = 8'h50;

   localparam logic [TRIM_W-1:0] RST_TRIM   = 16'hA000;
   localparam logic [TRIM_W-1:0] TRIM_MIN   = 16'h2000;
   localparam logic [7:0]        RST_CTRL8  = 8'h00;
   localparam logic [7:0]        RST_PLL3   = 8'h13;
   localparam logic [POS_W-1:0]  RST_POS    = 24'h000000;

   localparam int BIT_REF_BYPASS = 0;
   localparam int BIT_STAMP_EN   = 0;
   localparam int BIT_STAMP_PECL = 1;
   localparam int PE_LSB         = 0;
   localparam int BIT_PE_BOOST   = 3;
   localparam int SEL_LSB        = 0;
   localparam int BIT_AUTO_CAL   = 4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic              awvalid;
      logic [AXI_AW-1:0] awaddr;
      logic              wvalid;
      logic [AXI_DW-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [AXI_AW-1:0] araddr;
      logic              rready;
   } atsr_axil_req_s;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [AXI_DW-1:0] rdata;
      logic [1:0]        rresp;
   } atsr_axil_rsp_s;

   typedef struct packed {
      logic [TRIM_W-1:0]                trim_a;
      logic [TRIM_W-1:0]                trim_b;
      logic                             reference_bypass;
      logic                             stamp_receiver_enable;
      logic                             stamp_pecl_mode;
      logic [NUM_LANES-1:0][PE_W-1:0]   lane_preemphasis;
      logic [NUM_LANES-1:0]             lane_preemphasis_boost;
      logic [7:0]                       pll_loop_control_three;
      logic [SEL_W-1:0]                 capture_delay_select;
   } atsr_ctrl_s;

   typedef struct packed {
      logic              aw_ok;
      logic [AXI_AW-1:0] aw_addr;
      logic              w_ok;
      logic [AXI_DW-1:0] w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [AXI_DW-1:0] rdata;
      logic [1:0]        rresp;
      logic [POS_W-1:0]  cap_pos;
      logic              cap_tgl;
      logic [TRIM_W-1:0] trim_a;
      logic [TRIM_W-1:0] trim_b;
      logic [7:0]        ref_byp;
      logic [7:0]        stamp;
      logic [7:0]        pe;
      logic [7:0]        pll3;
      logic [7:0]        sel;
   } atsr_state_s;

endpackage

// *** rtl/atsr_sync.sv ***
// Two-stage synchroniser for levels entering the register clock domain
`timescale 1ns/1ps
`default_nettype none
module atsr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } atsr_sync_s;

   atsr_sync_s st_r;
   atsr_sync_s st_nxt;

   // First stage feeds only the second stage
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the trim and status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import atsr_pkg::*;
;
   logic             clk;
   logic             rst;
   atsr_axil_req_s   req;
   atsr_axil_rsp_s   rsp;
   logic [POS_W-1:0] cap_word;
   logic             cap_tgl;
   atsr_ctrl_s       ctrl;
   int               failures;
   int               tests_run;
   logic [31:0]      rd;

   // Register table: byte address, reset value, write value, readback
   localparam logic [9:0] RA [8] = '{{IDX_CAPTURE_POS, 2'h0}, {IDX_TRIM_A, 2'h0},
      {IDX_TRIM_B, 2'h0}, {IDX_REF_BYPASS, 2'h0}, {IDX_STAMP_CTRL, 2'h0},
      {IDX_PREEMPH, 2'h0}, {IDX_PLL_LOOP3, 2'h0}, {IDX_CAPTURE_SEL, 2'h0}};
   localparam logic [31:0] RV [8] = '{32'h0, 32'hA000, 32'hA000, 32'h0, 32'h0, 32'h0,
      32'h13, 32'h0};
   localparam logic [31:0] WV [8] = '{32'h0, 32'hFFFF1234, 32'h0000FFFF, 32'hFFFFFFFF,
      32'h000000FD, 32'h0000000D, 32'h000000A7, 32'h00000016};
   localparam logic [31:0] EV [8] = '{32'h0, 32'h1234, 32'hFFFF, 32'hFF, 32'hFD, 32'h0D,
      32'hA7, 32'h16};

   atsr_regs i_dut (
      .clk                   (clk),
      .rst                   (rst),
      .axil_req              (req),
      .axil_rsp              (rsp),
      .edge_capture_position (cap_word),
      .edge_capture_toggle   (cap_tgl),
      .ctrl                  (ctrl)
   );

   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Ready is sampled at the falling edge; inputs only move at rising edges,
   // so that value is the one the slave shows at the next rising edge
   task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic       aw_hs;
      logic       w_hs;
      logic       b_hs;
      logic [1:0] r;
      b_hs = 1'h0;
      r = 2'h3;
      @(posedge clk);
      req.awvalid <= 1'h1;
      req.awaddr <= a;
      req.wvalid <= 1'h1;
      req.wdata <= d;
      req.wstrb <= s;
      req.bready <= 1'h1;
      while (!b_hs) begin
         @(negedge clk);
         aw_hs = req.awvalid && rsp.awready;
         w_hs = req.wvalid && rsp.wready;
         b_hs = rsp.bvalid;
         r = rsp.bresp;
         @(posedge clk);
         if (aw_hs) req.awvalid <= 1'h0;
         if (w_hs) req.wvalid <= 1'h0;
         if (b_hs) req.bready <= 1'h0;
      end
      check({30'h0, r}, {30'h0, er});
   endtask

   task automatic rdc(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ar_hs;
      logic r_hs;
      logic [1:0] r;
      r_hs = 1'h0;
      r = 2'h3;
      @(posedge clk);
      req.arvalid <= 1'h1;
      req.araddr <= a;
      req.rready <= 1'h1;
      while (!r_hs) begin
         @(negedge clk);
         ar_hs = req.arvalid && rsp.arready;
         r_hs = rsp.rvalid;
         rd = rsp.rdata;
         r = rsp.rresp;
         @(posedge clk);
         if (ar_hs) req.arvalid <= 1'h0;
         if (r_hs) req.rready <= 1'h0;
      end
      check(rd, ed);
      check({30'h0, r}, {30'h0, er});
   endtask

   initial begin
      #(100 * 5000);
      failures++;
      print_verdict();
   end

   initial begin
      failures = 0;
      tests_run = 0;
      rst = 1'h1;
      req = '0;
      cap_word = '0;
      cap_tgl = 1'h0;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      check(32'(ctrl.trim_a), 32'hA000);
      check(32'(ctrl.pll_loop_control_three), 32'h13);
      check(32'(ctrl.lane_preemphasis_boost), 32'h0);
      check({29'h0, rsp.awready, rsp.wready, rsp.arready}, 32'h7);
      check({30'h0, rsp.bvalid, rsp.rvalid}, 32'h0);
      check(32'(ctrl.stamp_receiver_enable), 32'h0);
      for (int i = 0; i < 8; i++) begin
         rdc(RA[i], RV[i], RESP_OKAY);
      end
      // Full writes, trim A and reference bypass with junk in the upper bits; only the register width survives
      for (int i = 1; i < 8; i++) begin
         wr(RA[i], WV[i], 4'hF, RESP_OKAY);
         rdc(RA[i], EV[i], RESP_OKAY);
      end
      check(32'(ctrl.trim_a), 32'h1234);
      check(32'(ctrl.trim_b), 32'hFFFF);
      check(32'(ctrl.reference_bypass), 32'h1);
      check(32'(ctrl.stamp_receiver_enable), 32'h1);
      check(32'(ctrl.stamp_pecl_mode), 32'h0);
      for (int i = 0; i < NUM_LANES; i++) begin
         check(32'(ctrl.lane_preemphasis[i]), 32'h5);
      end
      check(32'(ctrl.lane_preemphasis_boost), 32'hFFFF);
      check(32'(ctrl.pll_loop_control_three), 32'hA7);
      check(32'(ctrl.capture_delay_select), 32'h0);
      wr({IDX_STAMP_CTRL, 2'h0}, 32'h02, 4'hF, RESP_OKAY);
      check(32'(ctrl.stamp_pecl_mode), 32'h1);
      check(32'(ctrl.stamp_receiver_enable), 32'h0);
      // Byte strobes: only the low byte of trim A may change
      wr({IDX_TRIM_A, 2'h0}, 32'hBEEF, 4'h1, RESP_OKAY);
      rdc({IDX_TRIM_A, 2'h0}, 32'h12EF, RESP_OKAY);
      wr({IDX_TRIM_B, 2'h0}, 32'h1111, 4'h0, RESP_OKAY);
      rdc({IDX_TRIM_B, 2'h0}, 32'hFFFF, RESP_OKAY);
      // Unmapped and misaligned places answer with an error
      wr(10'h3FC, 32'h55, 4'hF, RESP_SLVERR);
      rdc(10'h3FC, 32'h0, RESP_SLVERR);
      rdc({IDX_TRIM_A, 2'h2}, 32'h0, RESP_SLVERR);
      // Edge capture: word held steady around the toggle
      cap_word <= 24'h5A5A5A;
      repeat (3) @(posedge clk);
      cap_tgl <= ~cap_tgl;
      repeat (6) @(posedge clk);
      rdc({IDX_CAPTURE_POS, 2'h0}, 32'h5A5A5A, RESP_OKAY);
      wr({IDX_CAPTURE_SEL, 2'h0}, {28'h0, rd[3:0]}, 4'hF, RESP_OKAY);
      check(32'(ctrl.capture_delay_select), 32'hA);
      wr({IDX_CAPTURE_POS, 2'h0}, 32'hFFFFFF, 4'hF, RESP_OKAY);
      rdc({IDX_CAPTURE_POS, 2'h0}, 32'h5A5A5A, RESP_OKAY);
      // Second reset in mid-run restores the defaults
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      check(32'(ctrl.trim_b), 32'hA000);
      check(32'(ctrl.lane_preemphasis[0]), 32'h0);
      rdc({IDX_PREEMPH, 2'h0}, 32'h0, RESP_OKAY);
      rdc({IDX_REF_BYPASS, 2'h0}, 32'h0, RESP_OKAY);
      // Toggle stayed high through reset, so the held word is captured again
      rdc({IDX_CAPTURE_POS, 2'h0}, 32'h5A5A5A, RESP_OKAY);
      print_verdict();
   end
endmodule
`default_nettype wire
